//--- logic/hegi_consts.svh
// Purpose: Constants for the host event interrupt gate
// Assumes: Core clock of 100 MHz; four interrupters
// Notes:   Offsets are byte addresses on the plain register port
`ifndef HEGI_CONSTS_SVH
`define HEGI_CONSTS_SVH

// Sizes
`define HEGI_NUM_INTR        4
`define HEGI_TGT_W           2

// Register offsets (byte addresses)
`define HEGI_OFF_CTRL        8'h00
`define HEGI_OFF_PIN         8'h04
`define HEGI_OFF_STAT        8'h08
`define HEGI_OFF_MAN_BASE    8'h20
`define HEGI_OFF_MOD_BASE    8'h24
`define HEGI_OFF_STRIDE      8'h10

// Control register fields
`define HEGI_CTRL_MSI_BIT    0
`define HEGI_CTRL_PIN_BIT    1
`define HEGI_CTRL_EN_LSB     4
`define HEGI_CTRL_RESET      32'h0000_0000

// Management register fields (write one to clear)
`define HEGI_MAN_IP_BIT      0
`define HEGI_MAN_EHB_BIT     1

// Moderation register fields
`define HEGI_MOD_IVL_LSB     0
`define HEGI_MOD_CNT_LSB     16
`define HEGI_MOD_IVL_RESET   16'h0fa0

// Legacy pin number reported: 1 first pin, 2 second, 0 none
`define HEGI_LEGACY_PIN      8'h01

// Completion codes that may route by the slot target
`define HEGI_CC_TRANS_ERR    8'h04
`define HEGI_CC_STALL        8'h06
`define HEGI_CC_OVERRUN      8'h0e
`define HEGI_CC_UNDERRUN     8'h0f
`define HEGI_CC_INV_SID      8'h22
`define HEGI_CC_STOP_LEN     8'h1b
`define HEGI_CC_INV_STYPE    8'h23

// Moderation tick: 250 ns at a 10 ns clock
`define HEGI_TICK_NS         250
`define HEGI_CLK_NS          10
`define HEGI_TICK_CYC        (`HEGI_TICK_NS / `HEGI_CLK_NS)

`endif

//--- logic/hegi_pkg.sv
// Purpose: Types shared by the host event interrupt gate
// Assumes: Nothing beyond the constants header
// Notes:   Gray steps from idle to request to wait; the return to idle flips two bits
package hegi_pkg;

	// How an event type picks its interrupter
	typedef enum logic [1:0]
	{
		HEGI_RT_PRIMARY = 2'h0,
		HEGI_RT_TRB     = 2'h1,
		HEGI_RT_SLOT    = 2'h2
	} hegi_route_t;

	// Message write sequencer
	typedef enum logic [1:0]
	{
		HEGI_MS_IDLE = 2'h0,
		HEGI_MS_REQ  = 2'h1,
		HEGI_MS_WAIT = 2'h3
	} hegi_msg_t;

endpackage

//--- logic/hegi_evt_if.sv
// Purpose: Event description between the gate and its router
// Assumes: Both ends on core_clk
// Notes:   Router answers one cycle after the event is offered
interface hegi_evt_if;
	logic                    valid;      // Event offered this cycle
	hegi_pkg::hegi_route_t   mode;       // Routing method for its type
	logic [1:0]              trb_tgt;    // Target from the source TRB
	logic [1:0]              slot_tgt;   // Target from the slot context
	logic                    is_xfer;    // Event is a transfer event
	logic                    has_bei;    // Source TRB type has the flag
	logic                    block_interrupt_flag;        // block_interrupt_flag value
	logic                    err;        // Event produced by an error
	logic                    assoc;      // Tied to a transfer/data TRB
	logic                    prime;      // Stream fsm in prime-pipe state
	logic                    stop_wait;  // Stopped waiting for more TRBs
	logic [7:0]              code;       // Completion code
	logic                    post;       // Routed event ready
	logic [1:0]              tgt;        // Chosen interrupter
	logic                    nonblock;   // Event may raise an interrupt

	modport src
	(
		output valid, mode, trb_tgt, slot_tgt, is_xfer, has_bei, block_interrupt_flag,
		output err, assoc, prime, stop_wait, code,
		input  post, tgt, nonblock
	);
	modport rtr
	(
		input  valid, mode, trb_tgt, slot_tgt, is_xfer, has_bei, block_interrupt_flag,
		input  err, assoc, prime, stop_wait, code,
		output post, tgt, nonblock
	);
endinterface

//--- logic/hegi_router.sv
// Purpose: Picks the target interrupter and the blocking class
// Assumes: Event fields are stable in the cycle valid is high
// Notes:   Result is registered, one cycle after the offer
`include "hegi_consts.svh"

module hegi_router
(
	input  wire logic  clk,  // Core clock
	input  wire logic  rst,  // Synchronous reset, active high
	hegi_evt_if.rtr    ev    // Event in, routed event out
);

	logic       prime_code;  // Transaction error or stall in prime-pipe state
	logic       slot_code;   // Condition not tied to one TRB
	logic       use_slot;    // Transfer event routed by slot target
	logic [1:0] next_tgt;    // Interrupter chosen this cycle
	logic       next_block;  // Event is blocking

	// Conditions that cannot point at a specific TRB
	always_comb
	begin
		prime_code = ev.prime &&
			(ev.code == `HEGI_CC_TRANS_ERR ||
			 ev.code == `HEGI_CC_STALL);
		slot_code = prime_code ||
			ev.code == `HEGI_CC_INV_SID ||
			ev.code == `HEGI_CC_INV_STYPE ||
			ev.code == `HEGI_CC_OVERRUN ||
			ev.code == `HEGI_CC_UNDERRUN ||
			(ev.code == `HEGI_CC_STOP_LEN && ev.stop_wait);
		use_slot = ev.is_xfer && slot_code;
	end

	// Target selection by the method of the event type
	always_comb
	begin
		if (use_slot)
			next_tgt = ev.slot_tgt;
		else
		begin
			case (ev.mode)
				hegi_pkg::HEGI_RT_PRIMARY: next_tgt = 2'h0;
				hegi_pkg::HEGI_RT_TRB:     next_tgt = ev.trb_tgt;
				hegi_pkg::HEGI_RT_SLOT:    next_tgt = ev.slot_tgt;
				default:                   next_tgt = 2'h0;
			endcase
		end
	end

	// Blocking only with the flag set on a TRB that has it;
	// errors and events not tied to a transfer TRB never block
	always_comb
	begin
		next_block = ev.has_bei && ev.block_interrupt_flag;
		if (ev.err)
			next_block = 1'b0;
		if (!ev.assoc || use_slot)
			next_block = 1'b0;
	end

	// Registered answer
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ev.post     <= 1'b0;
			ev.tgt      <= 2'h0;
			ev.nonblock <= 1'b0;
		end
		else
		begin
			ev.post     <= ev.valid;
			ev.tgt      <= next_tgt;
			ev.nonblock <= !next_block;
		end
	end

endmodule

//--- logic/hegi_gate.sv
// Purpose: Decides when posted events raise a host interrupt
// Assumes: All inputs are on core_clk; message write handshake
//          from the bus logic comes back as a done pulse
// Notes:   Four interrupters; legacy pin uses interrupter 0 only
//
// How it works
// - Legacy line used only without message interrupts
// - Line held until pending flag cleared
// - Pin mode enables interrupter 0 only
// - Pin number: 1 first, 2 second, 0 none
// - Target: primary, TRB field or slot field
// - Untied transfer conditions route by slot target
// - Stopped-length uses slot only when waiting
// - Blocked events posted without interrupt
// - Flag at 1 blocks, otherwise non-blocking
// - Error events ignore the block flag
// - Events without transfer TRB never block
// - Pending-enable flag hidden from software
// - Pending-enable cleared on ring init or empty
// - Non-blocking insert sets pending-enable
// - Pending-enable rise sets pending when idle
// - Countdown reaching zero sets pending if enabled
// - Message mode clears pending after write done
// - Pending set also sets busy, reloads countdown
// - Moderation holds countdown and interval, 16 bits
// - Interval resets to 4000
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`include "hegi_consts.svh"

module hegi_gate
(
	input  wire logic        core_clk,           // Core clock
	input  wire logic        rst,                // Sync reset, high
	input  wire logic [7:0]  reg_addr,           // Register byte address
	input  wire logic [31:0] reg_wdata,          // Write data
	input  wire logic        reg_wr,             // Write strobe
	input  wire logic        reg_rd,             // Read strobe
	output logic      [31:0] reg_rdata,          // Read data, next cycle
	input  wire logic        evt_valid,          // Event offered
	input  wire logic [1:0]  evt_mode,           // Routing method
	input  wire logic [1:0]  evt_trb_tgt,        // TRB target field
	input  wire logic [1:0]  evt_slot_tgt,       // Slot target field
	input  wire logic        evt_is_xfer,        // Transfer event
	input  wire logic        evt_has_bei,        // TRB type has flag
	input  wire logic        evt_bei,            // block_interrupt_flag
	input  wire logic        evt_err,            // Error produced it
	input  wire logic        evt_assoc,          // Tied to transfer TRB
	input  wire logic        evt_prime,          // In prime-pipe state
	input  wire logic        evt_stop_wait,      // Stopped waiting
	input  wire logic [7:0]  evt_code,           // Completion code
	input  wire logic [3:0]  ring_init,          // Ring initialised, per intr
	input  wire logic [3:0]  ring_empty,         // Ring went empty, per intr
	output logic             evt_post,           // Event to ring, pulse
	output logic      [1:0]  evt_post_tgt,       // Its interrupter
	output logic             msi_req,            // Message write request
	output logic      [1:0]  msi_vec,            // Interrupter of write
	input  wire logic        msi_done,           // Write completed, pulse
	output logic             legacy_irq_line_n,  // Pin level, low active
	output logic             legacy_irq_oe       // High while pin driven
);

	localparam int N = `HEGI_NUM_INTR;

	hegi_evt_if ev ();                    // Link to the router

	logic [31:0] ctrl;                    // Control register
	logic        msi_en;                  // Message interrupts on
	logic        pin_en;                  // Legacy pin on
	logic [N-1:0] intr_en;                // Effective enables
	logic [N-1:0] ip;                     // irq_pending_flag
	logic [N-1:0] irq_pending_enable_flag;                    // irq_pending_enable_flag
	logic [N-1:0] ipe_q;                  // Previous pending-enable
	logic [N-1:0] handler_busy_flag;                    // handler_busy_flag
	logic [N-1:0] ip_set;                 // Pending set this cycle
	logic [N-1:0] ip_q;                   // Previous pending flag
	logic [N-1:0] owed;                   // Write owed for a rise
	logic [N-1:0] cnt_zero_q;             // Countdown was zero
	logic [15:0] mod_ivl [N];             // moderation_interval
	logic [15:0] mod_cnt [N];             // moderation_countdown
	logic [7:0]  tick_cnt;                // Prescaler to 250 ns
	logic        tick;                    // Countdown step
	hegi_pkg::hegi_msg_t ms_state;        // Message write state
	logic [1:0]  next_vec;                // Lowest owed interrupter
	logic        any_owed;                // Some write is owed
	logic [31:0] next_rdata;              // Read mux result

	// Router carries the event fields through the interface
	assign ev.valid     = evt_valid;
	assign ev.mode      = hegi_pkg::hegi_route_t'(evt_mode);
	assign ev.trb_tgt   = evt_trb_tgt;
	assign ev.slot_tgt  = evt_slot_tgt;
	assign ev.is_xfer   = evt_is_xfer;
	assign ev.has_bei   = evt_has_bei;
	assign ev.block_interrupt_flag       = evt_bei;
	assign ev.err       = evt_err;
	assign ev.assoc     = evt_assoc;
	assign ev.prime     = evt_prime;
	assign ev.stop_wait = evt_stop_wait;
	assign ev.code      = evt_code;

	hegi_router u_router
	(
		.clk (core_clk),
		.rst (rst),
		.ev  (ev)
	);

	// Routed event goes straight out to the ring writer
	assign evt_post     = ev.post;
	assign evt_post_tgt = ev.tgt;

	assign msi_en = ctrl[`HEGI_CTRL_MSI_BIT];
	assign pin_en = ctrl[`HEGI_CTRL_PIN_BIT];

	// Pin mode keeps only interrupter 0 alive
	always_comb
	begin
		intr_en = ctrl[`HEGI_CTRL_EN_LSB +: N];
		if (pin_en && !msi_en)
			intr_en = intr_en & 4'h1;
	end

	// Control register; message mode wins when both are set
	always_ff @(posedge core_clk)
	begin
		if (rst)
			ctrl <= `HEGI_CTRL_RESET;
		else if (reg_wr && reg_addr == `HEGI_OFF_CTRL)
			ctrl <= reg_wdata;
	end

	// Shared 250 ns prescaler for every countdown
	always_ff @(posedge core_clk)
	begin
		if (rst)
			tick_cnt <= 8'h00;
		else if (tick)
			tick_cnt <= 8'h00;
		else
			tick_cnt <= tick_cnt + 8'h01;
	end

	assign tick = (tick_cnt == 8'(`HEGI_TICK_CYC - 1));

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_intr
			localparam logic [7:0] MAN_OFF =
				8'(`HEGI_OFF_MAN_BASE + gi * `HEGI_OFF_STRIDE);
			localparam logic [7:0] MOD_OFF =
				8'(`HEGI_OFF_MOD_BASE + gi * `HEGI_OFF_STRIDE);
			logic ins_nb;                  // Non-blocking insert here
			logic man_wr;                  // Write to management
			logic mod_wr;                  // Write to moderation
			logic done_here;               // Message write completed

			assign ins_nb = ev.post && ev.nonblock &&
				ev.tgt == 2'(gi);
			assign man_wr = reg_wr && reg_addr == MAN_OFF;
			assign mod_wr = reg_wr && reg_addr == MOD_OFF;
			assign done_here = msi_done &&
				ms_state == hegi_pkg::HEGI_MS_WAIT && msi_vec == 2'(gi);

			// Pending-enable: insertion wins over a clear in the
			// same cycle, since the event is then on the ring;
			// no register exposes this flag
			always_ff @(posedge core_clk)
			begin
				if (rst)
					irq_pending_enable_flag[gi] <= 1'b0;
				else if (ins_nb)
					irq_pending_enable_flag[gi] <= 1'b1;
				else if (ring_init[gi] || ring_empty[gi])
					irq_pending_enable_flag[gi] <= 1'b0;
			end

			// Edges of pending-enable and of countdown zero
			always_ff @(posedge core_clk)
			begin
				if (rst)
				begin
					ipe_q[gi]      <= 1'b0;
					cnt_zero_q[gi] <= 1'b1;
				end
				else
				begin
					ipe_q[gi]      <= irq_pending_enable_flag[gi];
					cnt_zero_q[gi] <= mod_cnt[gi] == 16'h0000;
				end
			end

			// Pending-enable rising or countdown reaching zero
			assign ip_set[gi] = intr_en[gi] && !handler_busy_flag[gi] && irq_pending_enable_flag[gi] &&
				mod_cnt[gi] == 16'h0000 &&
				(!ipe_q[gi] ||
				 !cnt_zero_q[gi]);

			// Pending flag; a set beats any clear in the same cycle
			always_ff @(posedge core_clk)
			begin
				if (rst)
					ip[gi] <= 1'b0;
				else if (ip_set[gi])
					ip[gi] <= 1'b1;
				else if (done_here && msi_en)
					ip[gi] <= 1'b0;
				else if (man_wr && reg_wdata[`HEGI_MAN_IP_BIT])
					ip[gi] <= 1'b0;
			end

			// Busy flag set with pending, cleared by the handler
			always_ff @(posedge core_clk)
			begin
				if (rst)
					handler_busy_flag[gi] <= 1'b0;
				else if (ip_set[gi])
					handler_busy_flag[gi] <= 1'b1;
				else if (man_wr && reg_wdata[`HEGI_MAN_EHB_BIT])
					handler_busy_flag[gi] <= 1'b0;
			end

			// Interval and countdown; pending reloads the count
			always_ff @(posedge core_clk)
			begin
				if (rst)
				begin
					mod_ivl[gi] <= `HEGI_MOD_IVL_RESET;
					mod_cnt[gi] <= 16'h0000;
				end
				else if (ip_set[gi])
					mod_cnt[gi] <= mod_ivl[gi];
				else if (mod_wr)
				begin
					mod_ivl[gi] <= reg_wdata[`HEGI_MOD_IVL_LSB +: 16];
					mod_cnt[gi] <= reg_wdata[`HEGI_MOD_CNT_LSB +: 16];
				end
				else if (ring_init[gi])
					mod_ivl[gi] <= `HEGI_MOD_IVL_RESET;
				else if (tick && mod_cnt[gi] != 16'h0000)
					mod_cnt[gi] <= mod_cnt[gi] - 16'h0001;
			end

			// A write is owed once per pending rise in message mode
			always_ff @(posedge core_clk)
			begin
				if (rst)
					owed[gi] <= 1'b0;
				else if (ip[gi] && !ip_q[gi] && msi_en)
					owed[gi] <= 1'b1;
				else if (ms_state == hegi_pkg::HEGI_MS_IDLE &&
					any_owed && next_vec == 2'(gi))
					owed[gi] <= 1'b0;
			end
		end
	endgenerate

	// Previous pending flags for edge detection
	always_ff @(posedge core_clk)
	begin
		if (rst)
			ip_q <= '0;
		else
			ip_q <= ip;
	end

	// Lowest owed interrupter goes first; fixed priority may
	// delay higher numbers under heavy load, never lose them
	always_comb
	begin
		next_vec = 2'h0;
		for (int k = N - 1; k >= 0; k--)
		begin
			if (owed[k])
				next_vec = 2'(k);
		end
	end

	assign any_owed = |owed;

	// Message writes: one outstanding at a time
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ms_state <= hegi_pkg::HEGI_MS_IDLE;
			msi_req  <= 1'b0;
			msi_vec  <= 2'h0;
		end
		else
		begin
			case (ms_state)
				hegi_pkg::HEGI_MS_IDLE:
				begin
					if (any_owed)
					begin
						ms_state <= hegi_pkg::HEGI_MS_REQ;
						msi_req  <= 1'b1;
						msi_vec  <= next_vec;
					end
				end
				hegi_pkg::HEGI_MS_REQ:
				begin
					msi_req  <= 1'b0;
					ms_state <= hegi_pkg::HEGI_MS_WAIT;
				end
				hegi_pkg::HEGI_MS_WAIT:
				begin
					if (msi_done)
						ms_state <= hegi_pkg::HEGI_MS_IDLE;
				end
				default:
				begin
					ms_state <= hegi_pkg::HEGI_MS_IDLE;
					msi_req  <= 1'b0;
				end
			endcase
		end
	end

	// Legacy line follows pending of interrupter 0; never in
	// message mode. Open drain: drive low only while asserted
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			legacy_irq_line_n <= 1'b1;
			legacy_irq_oe     <= 1'b0;
		end
		else
		begin
			legacy_irq_oe     <= pin_en && !msi_en && ip[0];
			legacy_irq_line_n <= !(pin_en && !msi_en && ip[0]);
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (reg_addr == `HEGI_OFF_CTRL)
			next_rdata = ctrl;
		else if (reg_addr == `HEGI_OFF_PIN)
			next_rdata = {24'h00_0000, `HEGI_LEGACY_PIN};
		else if (reg_addr == `HEGI_OFF_STAT)
			next_rdata = {28'h000_0000, msi_vec,
				ms_state == hegi_pkg::HEGI_MS_WAIT,
				ms_state != hegi_pkg::HEGI_MS_IDLE};
		for (int k = 0; k < N; k++)
		begin
			if (reg_addr == 8'(`HEGI_OFF_MAN_BASE +
				k * `HEGI_OFF_STRIDE))
				next_rdata = {30'h0000_0000, handler_busy_flag[k], ip[k]};
			if (reg_addr == 8'(`HEGI_OFF_MOD_BASE +
				k * `HEGI_OFF_STRIDE))
				next_rdata = {mod_cnt[k], mod_ivl[k]};
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge core_clk)
	begin
		if (rst)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= 32'h0000_0000;
	end

endmodule

//--- verif/hegi_gate_properties.sv
// Purpose: Port checks for the host event interrupt gate
// Assumes: Bound to hegi_gate, one clock domain
// Notes:   Message mode is tracked from control register writes
`include "hegi_consts.svh"

module hegi_gate_props
(
	input wire logic        core_clk,          // Core clock
	input wire logic        rst,               // Sync reset, high
	input wire logic [7:0]  reg_addr,          // Register address
	input wire logic [31:0] reg_wdata,         // Write data
	input wire logic        reg_wr,            // Write strobe
	input wire logic        evt_valid,         // Event offered
	input wire logic        evt_post,          // Event routed
	input wire logic        msi_req,           // Message write request
	input wire logic        msi_done,          // Write completed
	input wire logic        legacy_irq_line_n, // Pin level
	input wire logic        legacy_irq_oe      // Pin driven
);
	timeunit 1ns;
	timeprecision 1ps;

	logic msi_on;   // Message mode as last written
	logic msi_on_d; // Same, a cycle late, lets the pin settle
	logic busy;     // A message write is still open
	wire  ctrl_wr = reg_wr && reg_addr == `HEGI_OFF_CTRL;
	wire  clr_ip0 = reg_wr && reg_addr == `HEGI_OFF_MAN_BASE
		&& reg_wdata[1:0] == 2'h1;

	// Mirror of the message enable
	always_ff @(posedge core_clk)
		if (rst)
			msi_on <= 1'b0;
		else if (ctrl_wr)
			msi_on <= reg_wdata[`HEGI_CTRL_MSI_BIT];

	always_ff @(posedge core_clk)
		msi_on_d <= msi_on;

	// Open from request until completion
	always_ff @(posedge core_clk)
		if (rst)
			busy <= 1'b0;
		else if (msi_req)
			busy <= 1'b1;
		else if (msi_done)
			busy <= 1'b0;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// Only a clear with the busy flag kept can free the pin for sure
	sequence s_clear_ip0;
		clr_ip0 && !legacy_irq_line_n;
	endsequence

	a_line_oe_pair: assert property (legacy_irq_oe == !legacy_irq_line_n)
		else $error("pin enable and level disagree");
	a_line_holds: assert property (!legacy_irq_line_n && !reg_wr
		&& !$past(reg_wr) && !$past(reg_wr, 2) |=> !legacy_irq_line_n)
		else $error("pin released without a clear");
	a_line_released: assert property (s_clear_ip0 |-> ##[1:3] legacy_irq_line_n)
		else $error("pin held after pending clear");
	a_no_pin_msi: assert property (msi_on && msi_on_d |-> legacy_irq_line_n)
		else $error("pin asserted in message mode");
	a_req_needs_msi: assert property (msi_req |-> msi_on)
		else $error("message write outside message mode");
	a_req_one_cycle: assert property (msi_req |=> !msi_req)
		else $error("write request longer than a cycle");
	a_req_not_open: assert property (msi_req |-> !busy)
		else $error("second write while one is open");
	a_post_follows: assert property (evt_valid |=> evt_post)
		else $error("event not posted");
	a_post_has_cause: assert property (evt_post |-> $past(evt_valid))
		else $error("post without an event");

	c_pin_seen: cover property ($fell(legacy_irq_line_n));
endmodule

bind hegi_gate hegi_gate_props u_props (.*);

//--- verif/hegi_host_model.sv
// Purpose: Host bus end that completes message writes
// Assumes: One write open at a time
// Notes:   Latency is chosen per scenario by the bench
module hegi_host_model
(
	input  wire logic       core_clk, // Core clock
	input  wire logic       rst,      // Sync reset, high
	input  wire logic       msi_req,  // Write request pulse
	input  wire logic [3:0] lat,      // Extra cycles before completion
	output logic            msi_done  // Completion pulse
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [4:0] cnt;  // Cycles left
	logic       open; // Write in flight

	// Each request completes once, never in its own cycle
	always_ff @(posedge core_clk)
	begin
		msi_done <= 1'b0;
		if (rst)
			open <= 1'b0;
		else if (msi_req)
		begin
			open <= 1'b1;
			cnt  <= {1'b0, lat};
		end
		else if (open && cnt == 5'h0)
		begin
			open     <= 1'b0;
			msi_done <= 1'b1;
		end
		else if (open)
			cnt <= cnt - 5'h1;
	end
endmodule

//--- verif/testbench.sv
// Purpose: Self-checking bench for the interrupt gate
// Assumes: Register port and event port driven on rising edges
// Notes:   Routing with no mode first, then pin mode, message mode last
`include "hegi_consts.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        core_clk, rst, reg_wr, reg_rd, evt_valid;
	logic        evt_is_xfer, evt_has_bei, evt_bei, evt_err;
	logic        evt_assoc, evt_prime, evt_stop_wait, msi_done;
	logic        msi_req, legacy_irq_line_n, legacy_irq_oe, evt_post;
	logic [1:0]  evt_mode, evt_trb_tgt, evt_slot_tgt, evt_post_tgt;
	logic [1:0]  msi_vec;
	logic [3:0]  ring_init, ring_empty, lat;
	logic [7:0]  reg_addr, evt_code;
	logic [31:0] reg_wdata, reg_rdata, rdv;
	int          n_mismatch, checked, n_req;
	wire  [2:0]  seen = {msi_req === 1'b1, legacy_irq_line_n === 1'b1,
		legacy_irq_line_n === 1'b0};
	localparam logic [7:0] SLOT_CC [6] = '{`HEGI_CC_TRANS_ERR,
		`HEGI_CC_STALL, `HEGI_CC_INV_SID, `HEGI_CC_INV_STYPE,
		`HEGI_CC_OVERRUN, `HEGI_CC_UNDERRUN};

	hegi_gate u_dut (.*);
	hegi_host_model u_host (.core_clk, .rst, .msi_req, .lat, .msi_done);

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Writes seen by the host side
	always @(posedge core_clk)
		if (msi_req === 1'b1)
			n_req++;

	task automatic check_word(string nm, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic check_bit(string nm, logic e, logic g);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Reads one word and compares the bits under the mask
	task automatic rd_chk(logic [7:0] a, logic [31:0] e, logic [31:0] m);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		rdv = reg_rdata;
		check_word("register", e, rdv & m);
	endtask

	// Flags: xfer, has flag, flag, error, tied, prime, waiting
	task automatic offer(logic [1:0] m, t, s, logic [6:0] f,
		logic [7:0] c, logic [1:0] e);
		@(posedge core_clk);
		evt_valid <= 1'b1;
		{evt_mode, evt_trb_tgt, evt_slot_tgt, evt_is_xfer, evt_has_bei,
			evt_bei, evt_err, evt_assoc, evt_prime, evt_stop_wait,
			evt_code} <= {m, t, s, f, c};
		@(posedge core_clk);
		evt_valid <= 1'b0;
		#1;
		check_word("target", {30'h0, e}, {30'h0, evt_post_tgt});
		check_bit("post", 1'b1, evt_post);
	endtask

	task automatic ring(logic [3:0] i, logic [3:0] e);
		@(posedge core_clk);
		ring_init  <= i;
		ring_empty <= e;
		@(posedge core_clk);
		ring_init  <= 4'h0;
		ring_empty <= 4'h0;
	endtask

	// 0 pin low, 1 pin high, 2 write request; bounded
	task automatic wait_for(int sel, int lim);
		int n;
		n = 0;
		while (seen[sel] !== 1'b1 && n < lim)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		// Judge by the flag, so a hit on the last cycle still counts
		if (seen[sel] !== 1'b1)
		begin
			check_bit("wait", 1'b1, 1'b0);
			finish_test();
		end
	endtask

	initial
	begin
		{rst, reg_wr, reg_rd, evt_valid} = 4'h8;
		{reg_addr, reg_wdata, ring_init, ring_empty, lat} = '0;
		{evt_mode, evt_trb_tgt, evt_slot_tgt, evt_code} = '0;
		{evt_is_xfer, evt_has_bei, evt_bei, evt_err} = '0;
		{evt_assoc, evt_prime, evt_stop_wait} = '0;
		{n_mismatch, checked, n_req} = '0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		rd_chk(`HEGI_OFF_PIN, 32'h1, '1);
		rd_chk(`HEGI_OFF_MOD_BASE, 32'h0fa0, '1);
		rd_chk(8'hfc, 32'h0, '1);
		// Routing with every interrupter disabled
		offer(2'h0, 2'h2, 2'h3, 7'h00, 8'h00, 2'h0);
		offer(2'h1, 2'h2, 2'h3, 7'h00, 8'h00, 2'h2);
		offer(2'h2, 2'h2, 2'h3, 7'h00, 8'h00, 2'h3);
		for (int i = 0; i < 6; i++)
			offer(2'h1, 2'h1, 2'h2, 7'h42, SLOT_CC[i], 2'h2);
		offer(2'h1, 2'h1, 2'h2, 7'h41, `HEGI_CC_STOP_LEN, 2'h2);
		offer(2'h1, 2'h1, 2'h2, 7'h44, `HEGI_CC_STOP_LEN, 2'h1);
		rd_chk(`HEGI_OFF_MAN_BASE, 32'h0, '1);
		// Pin mode, interrupter 0, short interval
		ring(4'hf, 4'h0);
		wr(`HEGI_OFF_CTRL, 32'h12);
		wr(`HEGI_OFF_MOD_BASE, 32'h8);
		offer(2'h0, 2'h0, 2'h0, 7'h00, 8'h00, 2'h0);
		wait_for(0, 8);
		rd_chk(`HEGI_OFF_MAN_BASE, 32'h3, '1);
		rd_chk(`HEGI_OFF_MOD_BASE, 32'h8, 32'hffff);
		check_bit("countdown", 1'b1, |rdv[31:16]);
		repeat (10) @(posedge core_clk);
		check_bit("pin", 1'b0, legacy_irq_line_n);
		check_bit("pin drive", 1'b1, legacy_irq_oe);
		wr(`HEGI_OFF_MAN_BASE, 32'h1);
		wait_for(1, 3);
		wr(`HEGI_OFF_MAN_BASE, 32'h2);
		repeat (2) @(posedge core_clk);
		check_bit("pin", 1'b1, legacy_irq_line_n);
		wait_for(0, 250);
		wr(`HEGI_OFF_MAN_BASE, 32'h3);
		wait_for(1, 3);
		ring(4'h0, 4'h1);
		repeat (250) @(posedge core_clk);
		check_bit("pin", 1'b1, legacy_irq_line_n);
		offer(2'h0, 2'h0, 2'h0, 7'h74, 8'h00, 2'h0);
		repeat (6) @(posedge core_clk);
		check_bit("pin", 1'b1, legacy_irq_line_n);
		offer(2'h0, 2'h0, 2'h0, 7'h7c, 8'h00, 2'h0);
		wait_for(0, 8);
		wr(`HEGI_OFF_MAN_BASE, 32'h3);
		wait_for(1, 3);
		// Pin mode keeps interrupter 1 off
		wr(`HEGI_OFF_CTRL, 32'h32);
		offer(2'h1, 2'h1, 2'h0, 7'h00, 8'h00, 2'h1);
		repeat (6) @(posedge core_clk);
		rd_chk(`HEGI_OFF_MAN_BASE + `HEGI_OFF_STRIDE, 32'h0, '1);
		// Message mode, slow then prompt completion
		wr(`HEGI_OFF_CTRL, 32'hf1);
		ring(4'hf, 4'h0);
		lat <= 4'h5;
		offer(2'h1, 2'h2, 2'h0, 7'h00, 8'h00, 2'h2);
		wait_for(2, 8);
		check_word("vector", 32'h2, {30'h0, msi_vec});
		repeat (12) @(posedge core_clk);
		rd_chk(`HEGI_OFF_MAN_BASE + 8'h20, 32'h2, '1);
		lat <= 4'h0;
		offer(2'h1, 2'h1, 2'h3, 7'h70, `HEGI_CC_INV_SID, 2'h3);
		wait_for(2, 8);
		check_word("vector", 32'h3, {30'h0, msi_vec});
		repeat (12) @(posedge core_clk);
		check_word("writes", 32'h2, n_req);
		finish_test();
	end
endmodule
